// *** dv/ring_fairness_token_control_test.sv ***
// Self-checking bench for the ring fairness token controller
`timescale 1ns/1ns
module ring_fairness_token_control_test;
  logic clk_sys = 1'b0; // Character clock
  logic reset = 1'b1; // Synchronous reset
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd; // Last read data
  logic pready;
  logic pslverr;
  logic err; // Last error response
  ring_fair_pkg::port_in_t [1:0] port; // Link state, driven by the bench
  ring_fair_pkg::token_t [1:0] rx_tok;
  ring_fair_pkg::token_t [1:0] tx_tok;
  logic [1:0] may_orig;
  logic [1:0] hold_cut;
  int num_errors = 0;
  int checks = 0;

  // Short loss timer: quiet between the early releases, yet short enough for test_loss to see it fire
  ring_fairness_token_control #(.TOKEN_LOSS_CYCLES(500)) i_ring_fairness_token_control (
    .i_clk_sys(clk_sys), .i_reset(reset), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_port(port), .i_rx_tok(rx_tok), .o_tx_tok(tx_tok), .o_may_originate(may_orig), .o_hold_cut(hold_cut));
  ring_peer_model i_ring_peer_model (.i_clk_sys(clk_sys), .i_tx_tok(tx_tok), .o_rx_tok(rx_tok));

  initial
  begin
    forever #2 clk_sys = ~clk_sys;
  end

  // ------------------------------------------------
  // Shared tasks
  // ------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  // One APB transfer; waits for pready, taken at that edge; only the watchdog ends a hung wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic int cnt(input int p, input logic ret);
    return ret ? i_ring_peer_model.got_ret[p] : i_ring_peer_model.got_fair[p];
  endfunction

  // Watch port p up to lim cycles; want says whether a token must appear
  task automatic tok(input int p, input logic ret, input int lim, input logic want, input string m);
    int n0;
    n0 = cnt(p, ret);
    repeat (lim)
    begin
      @(posedge clk_sys);
      if (cnt(p, ret) != n0)
        break;
    end
    check(32'(cnt(p, ret) != n0), 32'(want), m);
  endtask

  // Trailing flag of one originated frame
  task automatic frame(input int p);
    @(posedge clk_sys);
    port[p].app_sent <= 1'b1;
    @(posedge clk_sys);
    port[p].app_sent <= 1'b0;
  endtask

  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic test_regs();
    apb(1'b0, ring_fair_pkg::ADDR_QUOTA0, 32'h0);
    check(rd, 32'h0000_0401, "quota reset value");
    apb(1'b0, 8'h14, 32'h0);
    check(32'(err), 32'h1, "unmapped address accepted");
    apb(1'b1, ring_fair_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
    check(32'(err), 32'h1, "status write accepted");
    $display("test_regs done");
  endtask

  task automatic test_forward();
    port[0].outstanding <= 8'h01;
    port[0].app_pending <= 1'b1;
    i_ring_peer_model.send(0, 1'b0);
    tok(1, 1'b0, 20, 1'b0, "token released unsatisfied");
    check(32'(hold_cut[0]), 32'h1, "cut through not held");
    check(32'(may_orig[0]), 32'h1, "origination blocked while holding");
    frame(0);
    tok(1, 1'b0, 150, 1'b1, "fairness token not forwarded");
    apb(1'b0, ring_fair_pkg::ADDR_COUNT, 32'h0);
    check(rd, 32'h0, "counter not cleared");
    port[0].cut_pending <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check(32'(may_orig[0]), 32'h0, "origination beside cut through");
    port[0].cut_pending <= 1'b0;
    repeat (4) frame(0);
    apb(1'b0, ring_fair_pkg::ADDR_COUNT, 32'h0);
    check(rd, 32'h4, "frame count wrong");
    check(32'(may_orig[0]), 32'h0, "origination at idle limit");
    i_ring_peer_model.send(0, 1'b0);
    tok(1, 1'b0, 150, 1'b1, "token kept at idle limit");
    check(32'(may_orig[0]), 32'h1, "origination not resumed");
    $display("test_forward done");
  endtask

  task automatic test_return();
    i_ring_peer_model.send(1, 1'b0);
    tok(0, 1'b0, 150, 1'b1, "second direction not forwarded");
    i_ring_peer_model.send(0, 1'b1);
    tok(1, 1'b1, 10, 1'b1, "return token not forwarded");
    i_ring_peer_model.send(0, 1'b1);
    tok(1, 1'b1, 20, 1'b0, "stale return token forwarded");
    $display("test_return done");
  endtask

  task automatic test_reflect();
    apb(1'b1, ring_fair_pkg::ADDR_CTRL, 32'h1);
    apb(1'b0, ring_fair_pkg::ADDR_STATUS, 32'h0);
    check(rd & 32'h10, 32'h10, "turnaround not set");
    i_ring_peer_model.send(0, 1'b1);
    tok(0, 1'b0, 10, 1'b1, "return token not turned");
    port[0].outstanding <= 8'h00;
    port[0].ready <= 1'b0;
    i_ring_peer_model.send(0, 1'b0);
    tok(0, 1'b1, 150, 1'b0, "token sent outside ready");
    port[0].ready <= 1'b1;
    tok(0, 1'b1, 10, 1'b1, "fairness token not reflected");
    $display("test_reflect done");
  endtask

  // Sync loss, string end by a dead port, and a token recreated by the loss timer
  task automatic test_loss();
    port[1].sync <= 1'b0;
    i_ring_peer_model.send(1, 1'b0);
    tok(1, 1'b1, 20, 1'b0, "token taken without sync");
    port[1].sync <= 1'b1;
    apb(1'b1, ring_fair_pkg::ADDR_CTRL, 32'h0);
    port[1].operational <= 1'b0;
    tok(1, 1'b1, 600, 1'b1, "lost token not recreated at string end");
    i_ring_peer_model.send(1, 1'b1);
    tok(1, 1'b0, 10, 1'b1, "string end did not turn return token");
    $display("test_loss done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Main sequence: both links synced, ready and operational
  initial
  begin
    port[0] = '{sync: 1'b1, ready: 1'b1, operational: 1'b1, default: '0};
    port[1] = port[0];
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    test_regs();
    test_forward();
    test_return();
    test_reflect();
    test_loss();
    results();
  end

  // Watchdog: the scenarios need well under 3000 cycles
  initial
  begin
    repeat (3000) @(posedge clk_sys);
    num_errors++;
    results();
  end
endmodule

// *** dv/ring_peer_model.sv ***
// Neighbouring node ports: token source and token sink
`timescale 1ns/1ns
module ring_peer_model (
  input wire logic i_clk_sys,
  input wire ring_fair_pkg::token_t [1:0] i_tx_tok,
  output ring_fair_pkg::token_t [1:0] o_rx_tok
);
  int got_fair [2] = '{0, 0}; // Fairness tokens seen per port
  int got_ret [2] = '{0, 0}; // Return tokens seen per port

  initial
  begin
    o_rx_tok = '0;
  end

  // Tally each token pulse; a pulse lasts one cycle
  always @(posedge i_clk_sys)
  begin
    for (int p = 0; p < 2; p++)
    begin
      got_fair[p] <= got_fair[p] + int'(i_tx_tok[p].fair === 1'b1);
      got_ret[p] <= got_ret[p] + int'(i_tx_tok[p].ret === 1'b1);
    end
  end

  // One token character, held for one cycle; test_loss sends one with sync dropped
  task automatic send(input int p, input logic ret);
    o_rx_tok[p] <= ret ? 2'h1 : 2'h2;
    @(posedge i_clk_sys);
    o_rx_tok[p] <= 2'h0;
  endtask
endmodule

// *** hdl/interval_timer.sv ***
// Saturating interval counter with a registered reached flag
`timescale 1ns/1ns
module interval_timer #(
  parameter int LIMIT = 100
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_clear,
  output logic o_reached
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [ring_fair_pkg::TMR_W-1:0] count; // Cycles since last clear
    logic reached;                          // Count has hit the limit
  } tmr_state_t;

  localparam logic [ring_fair_pkg::TMR_W-1:0] LIMIT_V = ring_fair_pkg::TMR_W'(LIMIT);

  tmr_state_t st_reg;
  tmr_state_t st_next;

  // Count up to the limit and stop there, so the flag stays up until cleared
  always_comb
  begin
    st_next = st_reg;
    if (i_clear)
    begin
      st_next.count = '0;
    end
    else if (st_reg.count < LIMIT_V)
    begin
      st_next.count = st_reg.count + 1'b1;
    end
    st_next.reached = (st_next.count >= LIMIT_V);
  end

  // Register the state
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign o_reached = st_reg.reached;

endmodule

// *** hdl/quota_scale.sv ***
// Registered product of a quota base and the outstanding transfer count
`timescale 1ns/1ns
module quota_scale (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic [ring_fair_pkg::QUOTA_W-1:0] i_base,
  input wire logic [ring_fair_pkg::QUOTA_W-1:0] i_outstanding,
  output logic [ring_fair_pkg::CNT_W-1:0] o_limit
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [ring_fair_pkg::CNT_W-1:0] limit; // Scaled limit
  } scale_state_t;

  scale_state_t st_reg;
  scale_state_t st_next;

  // 8 x 8 product fits the counter width exactly; one cycle of lag is harmless
  always_comb
  begin
    st_next.limit = ring_fair_pkg::CNT_W'(i_base * i_outstanding);
  end

  // Register the state
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign o_limit = st_reg.limit;

endmodule

// *** hdl/ring_fair_pkg.sv ***
// Constants, carrier types and state layouts for the ring fairness token controller
// Operation
// - Held limit is hold base times outstanding
// - Idle limit is idle base times outstanding
// - Counter counts frames, cleared on token release
// - Count only on trailing flag, never aborts
// - Satisfied: count reached held limit, or idle
// - Turnaround flag selects forward or reflect
// - Forward fairness token out the other port
// - Forward return token out other port only after a fairness token was seen there
// - Reflect fairness token as return, same port
// - Reflect return token as fairness, same port
// - Keep token until Satisfied, then release
// - Privileged and Control frames bypass fairness
// - Originate when holding unsatisfied, or idle room
// - Below held limit: hold cut through traffic
// - Between limits: originate only without cut through
// - At idle limit: originate nothing at all
// - Accept tokens when synced, send only Ready
// - Separate fairness state for each direction
// - String end reflects fairness token once Satisfied
// - String end turns return token, counter kept
// - Discard stale return token in closed loop
// - Token loss timer recreates lost fairness token
// - At least 100 characters between releases
package ring_fair_pkg;

  // --------------------------------------------------------------------
  // Register map, byte addresses on the APB
  // --------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_QUOTA0 = 8'h04;
  localparam logic [7:0] ADDR_QUOTA1 = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_COUNT = 8'h10;

  // Field positions and widths
  localparam int QUOTA_W = 8;
  localparam int HOLD_LSB = 0;
  localparam int IDLE_LSB = 8;
  localparam int CNT_W = 16;
  localparam int STAT_HOLD_LSB = 0;
  localparam int STAT_SAT_LSB = 2;
  localparam int STAT_TURN_LSB = 4;
  localparam int COUNT1_LSB = 16;

  // Reset values
  localparam logic [QUOTA_W-1:0] HOLD_BASE_RST = 8'h01;
  localparam logic [QUOTA_W-1:0] IDLE_BASE_RST = 8'h04;
  localparam logic [1:0] SPLIT_RST = 2'h0;

  // --------------------------------------------------------------------
  // Timing: one character period per clock in the character domain
  // --------------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int TOKEN_LOSS_MS = 100;
  localparam int TOKEN_LOSS_CYCLES = TOKEN_LOSS_MS * 1000 * CLK_MHZ;
  localparam int CHAR_CLKS = 1;
  localparam int TOKEN_GAP_CHARS = 100;
  localparam int TOKEN_GAP_CYCLES = TOKEN_GAP_CHARS * CHAR_CLKS;
  localparam int TMR_W = 26;

  // --------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------
  // One token character seen or sent on a port
  typedef struct packed {
    logic fair;
    logic ret;
  } token_t;

  // Link-layer view of one port, same clock domain
  typedef struct packed {
    logic sync;                 // Character synchronization held
    logic ready;                // Ready state, token slot free
    logic operational;          // Port is operational
    logic app_pending;          // Application frame waiting to go out
    logic cut_pending;          // Cut-through frame waiting to go out
    logic app_sent;             // Trailing flag of an Application frame sent
    logic [QUOTA_W-1:0] outstanding; // Outbound data transfers in flight
  } port_in_t;

  // Fairness state of one direction
  typedef struct packed {
    logic holding;              // Fairness token held
    logic seen_fair;            // Fairness token on other port since last return here
    logic fair_pend;            // Fairness token queued for this port's outbound
    logic ret_pend;             // Return token queued for this port's outbound
    logic [CNT_W-1:0] frames;   // Origination counter
  } dir_state_t;

endpackage

// *** hdl/ring_fairness_token_control.sv ***
// Dual-port fairness token controller with APB register access
`timescale 1ns/1ns
module ring_fairness_token_control #(
  parameter int TOKEN_LOSS_CYCLES = ring_fair_pkg::TOKEN_LOSS_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire ring_fair_pkg::port_in_t [1:0] i_port,
  input wire ring_fair_pkg::token_t [1:0] i_rx_tok,
  output ring_fair_pkg::token_t [1:0] o_tx_tok,
  output logic [1:0] o_may_originate,
  output logic [1:0] o_hold_cut
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    ring_fair_pkg::dir_state_t [1:0] dir;        // Per receiving port
    logic [1:0] split;                            // Region split bits
    logic [1:0][ring_fair_pkg::QUOTA_W-1:0] hold_base;
    logic [1:0][ring_fair_pkg::QUOTA_W-1:0] idle_base;
    ring_fair_pkg::token_t [1:0] tx;              // Token send strobes
    logic [1:0] may_orig;                         // Origination grant
    logic [1:0] hold_cut;                         // Stall cut-through
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ctl_state_t;

  ctl_state_t st_reg;
  ctl_state_t st_next;

  logic [1:0][ring_fair_pkg::CNT_W-1:0] hold_lim; // Scaled held limit
  logic [1:0][ring_fair_pkg::CNT_W-1:0] idle_lim; // Scaled idle limit
  logic [1:0] loss_hit;                           // Token loss timer expired
  logic [1:0] gap_ok;                             // Release spacing met
  logic [1:0] satisfied;                          // Satisfied per direction
  logic [1:0] release_tok;                        // Token leaves this cycle
  logic turnaround;                               // Node reflects tokens
  logic both_op;                                  // Both ports operational

  // ------------------------------------------------------------
  // Register decode, shared by read and write paths
  // ------------------------------------------------------------
  function automatic logic [2:0] reg_sel(input logic [7:0] addr);
    unique case (addr)
      ring_fair_pkg::ADDR_CTRL: reg_sel = 3'h1;
      ring_fair_pkg::ADDR_QUOTA0: reg_sel = 3'h2;
      ring_fair_pkg::ADDR_QUOTA1: reg_sel = 3'h3;
      ring_fair_pkg::ADDR_STATUS: reg_sel = 3'h4;
      ring_fair_pkg::ADDR_COUNT: reg_sel = 3'h5;
      default: reg_sel = 3'h0;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Per-port helpers: limits and timers
  // ------------------------------------------------------------
  for (genvar p = 0; p < 2; p++)
  begin : g_port
    quota_scale u_hold (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_base(st_reg.hold_base[p]),
      .i_outstanding(i_port[p].outstanding),
      .o_limit(hold_lim[p])
    );
    quota_scale u_idle (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_base(st_reg.idle_base[p]),
      .i_outstanding(i_port[p].outstanding),
      .o_limit(idle_lim[p])
    );
    // Loss timer restarts on every release
    interval_timer #(.LIMIT(TOKEN_LOSS_CYCLES)) u_loss (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_clear(release_tok[p]),
      .o_reached(loss_hit[p])
    );
    interval_timer #(.LIMIT(ring_fair_pkg::TOKEN_GAP_CYCLES)) u_gap (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_clear(release_tok[p]),
      .o_reached(gap_ok[p])
    );
  end

  // ------------------------------------------------------------
  // Satisfied and release decisions
  // ------------------------------------------------------------
  always_comb
  begin
    both_op = i_port[0].operational & i_port[1].operational;
    // Split bit or a string end turns tokens around
    turnaround = (|st_reg.split) | ~both_op;
    for (int p = 0; p < 2; p++)
    begin
      // Quota met, or holding with nothing to send
      satisfied[p] = (st_reg.dir[p].frames >= hold_lim[p]) |
                     (st_reg.dir[p].holding & ~i_port[p].app_pending);
      // Held token leaves only once Satisfied and spaced out
      release_tok[p] = st_reg.dir[p].holding & satisfied[p] & gap_ok[p];
    end
  end

  // ------------------------------------------------------------
  // Next-state logic: tokens, counters, grants and the APB slave
  // ------------------------------------------------------------
  always_comb
  begin
    logic [2:0] sel;
    int o;
    sel = reg_sel(i_paddr);
    o = 0;
    st_next = st_reg;

    // Each receiving port carries its own direction's state
    for (int p = 0; p < 2; p++)
    begin
      o = 1 - p;

      // Token send only in Ready; fairness first, one per cycle
      st_next.tx[p] = '0;
      if (i_port[p].ready & st_reg.dir[p].fair_pend)
      begin
        st_next.tx[p].fair = 1'b1;
        st_next.dir[p].fair_pend = 1'b0;
      end
      else if (i_port[p].ready & st_reg.dir[p].ret_pend)
      begin
        st_next.tx[p].ret = 1'b1;
        st_next.dir[p].ret_pend = 1'b0;
      end
    end

    for (int p = 0; p < 2; p++)
    begin
      o = 1 - p;

      // Incoming fairness token taken only with sync; a second one merges
      // An expired loss timer creates a token as if received
      if ((i_rx_tok[p].fair & i_port[p].sync) | loss_hit[p])
      begin
        st_next.dir[p].holding = 1'b1;
      end

      // Track fairness arrivals on the other port; arrival beats clear
      if (i_rx_tok[o].fair & i_port[o].sync)
      begin
        st_next.dir[p].seen_fair = 1'b1;
      end
      else if (i_rx_tok[p].ret & i_port[p].sync)
      begin
        st_next.dir[p].seen_fair = 1'b0;
      end

      // Return token handling
      if (i_rx_tok[p].ret & i_port[p].sync)
      begin
        if (turnaround)
        begin
          // Turn around at once, counter untouched
          st_next.dir[p].fair_pend = 1'b1;
        end
        else if (st_reg.dir[p].seen_fair)
        begin
          // Pass straight through to the other port
          st_next.dir[o].ret_pend = 1'b1;
        end
        // Otherwise stale in a closed loop: dropped
      end

      // Count only completed Application frames, saturating
      if (i_port[p].app_sent && st_reg.dir[p].frames != '1)
      begin
        st_next.dir[p].frames = st_reg.dir[p].frames + 1'b1;
      end

      if (release_tok[p])
      begin
        st_next.dir[p].holding = 1'b0;
        // Restart the count; a frame ending now counts afresh
        st_next.dir[p].frames = ring_fair_pkg::CNT_W'(i_port[p].app_sent);
        if (turnaround)
        begin
          // Reflect as a return token on the same port
          st_next.dir[p].ret_pend = 1'b1;
        end
        else
        begin
          // Forward as a fairness token on the other port
          st_next.dir[o].fair_pend = 1'b1;
        end
      end

      // Application frames only; Privileged and Control
      // frames never consult this grant.
      st_next.may_orig[p] = (st_reg.dir[p].holding & ~satisfied[p]) |
                            (~i_port[p].cut_pending & (idle_lim[p] > st_reg.dir[p].frames));
      // Holding and unsatisfied: own frames go before cut-through
      st_next.hold_cut[p] = st_reg.dir[p].holding & ~satisfied[p];
    end

    // APB: one wait state, answer registered
    st_next.pready = i_psel & i_penable & ~st_reg.pready;
    st_next.pslverr = 1'b0;
    st_next.prdata = '0;
    if (i_psel & i_penable & ~st_reg.pready)
    begin
      // Unmapped addresses and writes to read-only words report an error
      st_next.pslverr = (sel == 3'h0) | (i_pwrite & (sel > 3'h3));
      if (i_pwrite)
      begin
        unique case (sel)
          3'h1: st_next.split = i_pwdata[1:0];
          3'h2:
          begin
            st_next.hold_base[0] = i_pwdata[ring_fair_pkg::HOLD_LSB +: ring_fair_pkg::QUOTA_W];
            st_next.idle_base[0] = i_pwdata[ring_fair_pkg::IDLE_LSB +: ring_fair_pkg::QUOTA_W];
          end
          3'h3:
          begin
            st_next.hold_base[1] = i_pwdata[ring_fair_pkg::HOLD_LSB +: ring_fair_pkg::QUOTA_W];
            st_next.idle_base[1] = i_pwdata[ring_fair_pkg::IDLE_LSB +: ring_fair_pkg::QUOTA_W];
          end
          default: st_next.pslverr = st_next.pslverr;
        endcase
      end
      else
      begin
        unique case (sel)
          3'h1: st_next.prdata[1:0] = st_reg.split;
          3'h2:
          begin
            st_next.prdata[ring_fair_pkg::HOLD_LSB +: ring_fair_pkg::QUOTA_W] = st_reg.hold_base[0];
            st_next.prdata[ring_fair_pkg::IDLE_LSB +: ring_fair_pkg::QUOTA_W] = st_reg.idle_base[0];
          end
          3'h3:
          begin
            st_next.prdata[ring_fair_pkg::HOLD_LSB +: ring_fair_pkg::QUOTA_W] = st_reg.hold_base[1];
            st_next.prdata[ring_fair_pkg::IDLE_LSB +: ring_fair_pkg::QUOTA_W] = st_reg.idle_base[1];
          end
          3'h4:
          begin
            st_next.prdata[ring_fair_pkg::STAT_HOLD_LSB] = st_reg.dir[0].holding;
            st_next.prdata[ring_fair_pkg::STAT_HOLD_LSB + 1] = st_reg.dir[1].holding;
            st_next.prdata[ring_fair_pkg::STAT_SAT_LSB +: 2] = satisfied;
            st_next.prdata[ring_fair_pkg::STAT_TURN_LSB] = turnaround;
          end
          3'h5:
          begin
            st_next.prdata[ring_fair_pkg::CNT_W-1:0] = st_reg.dir[0].frames;
            st_next.prdata[ring_fair_pkg::COUNT1_LSB +: ring_fair_pkg::CNT_W] = st_reg.dir[1].frames;
          end
          default: st_next.prdata = '0;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      st_reg <= '0;
      st_reg.split <= ring_fair_pkg::SPLIT_RST;
      st_reg.hold_base <= {2{ring_fair_pkg::HOLD_BASE_RST}};
      st_reg.idle_base <= {2{ring_fair_pkg::IDLE_BASE_RST}};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flops
  assign o_tx_tok = st_reg.tx;
  assign o_may_originate = st_reg.may_orig;
  assign o_hold_cut = st_reg.hold_cut;
  assign o_prdata = st_reg.prdata;
  assign o_pready = st_reg.pready;
  assign o_pslverr = st_reg.pslverr;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  for (genvar p = 0; p < 2; p++)
  begin : g_chk
    localparam int O = 1 - p;
    chk_tx_needs_ready: assert property (
      (o_tx_tok[p].fair | o_tx_tok[p].ret) |-> $past(i_port[p].ready))
      else $error("token sent while port not Ready");
    chk_release_clears: assert property (
      release_tok[p] |=> (st_reg.dir[p].frames <= 16'h0001) && !st_reg.dir[p].holding)
      else $error("release did not clear counter");
    chk_count_step: assert property (
      (i_port[p].app_sent && !release_tok[p] && st_reg.dir[p].frames < 16'h00FF)
      |=> st_reg.dir[p].frames == $past(st_reg.dir[p].frames) + 16'h0001)
      else $error("counter missed an originated frame");
    chk_keep_unsat: assert property (
      (st_reg.dir[p].holding && !satisfied[p]) |=> st_reg.dir[p].holding)
      else $error("token released while not Satisfied");
    chk_release_gap: assert property (
      release_tok[p] |=> !release_tok[p] [*8])
      else $error("releases too close together");
    chk_forward_dir: assert property (
      (release_tok[p] && !turnaround) |=> st_reg.dir[O].fair_pend)
      else $error("forwarded token not queued on other port");
    chk_reflect_dir: assert property (
      (release_tok[p] && turnaround) |=> st_reg.dir[p].ret_pend)
      else $error("reflected token not queued on same port");
    chk_ret_turn: assert property (
      (i_rx_tok[p].ret && i_port[p].sync && turnaround) |=> st_reg.dir[p].fair_pend)
      else $error("return token not turned around");
    chk_stale_drop: assert property (
      (i_rx_tok[p].ret && i_port[p].sync && !turnaround && !st_reg.dir[p].seen_fair
       && !st_reg.dir[O].ret_pend) |=> !st_reg.dir[O].ret_pend)
      else $error("stale return token forwarded");
    chk_idle_block: assert property (
      (st_reg.dir[p].frames >= idle_lim[p] && !st_reg.dir[p].holding) |=> !o_may_originate[p])
      else $error("origination granted past idle limit");
    cov_forward: cover property (release_tok[p] && !turnaround);
    cov_reflect: cover property (release_tok[p] && turnaround);
    cov_ret_pass: cover property (o_tx_tok[p].ret && !turnaround);
  end

endmodule
